//--- src_ctrl_params.svh
// Register offsets, field positions, reset values and coefficients of the converter control
`ifndef SRC_CTRL_PARAMS_SVH
`define SRC_CTRL_PARAMS_SVH
`define REG_CTRL1          7'h2D
`define REG_FILTER         7'h2E
`define REG_WORDLEN        7'h2F
`define REG_ATTEN_L        7'h30
`define REG_ATTEN_R        7'h31
`define CTRL1_TRACK        6
`define CTRL1_MUTE         4
`define CTRL1_REFCLK       3:2
`define CTRL1_INSRC        1:0
`define FILT_AUTO          5
`define FILT_DEM           4:3
`define FILT_DDN           2
`define FILT_PREBUFFER_DEPTH_SELECT          1:0
`define WL_OWL             7:6
`define RESET_BYTE         8'h00
`define REF_RESERVED       2'h3
`define DEPTH_64           7'h40
`define DEPTH_32           7'h20
`define DEPTH_16           7'h10
`define DEPTH_8            7'h08
`define DEM_OFF            2'h0
`define DEM_48             2'h1
`define DEM_441            2'h2
`define DEM_32             2'h3
`define CS_FS_441          4'h0
`define CS_FS_48           4'h2
`define CS_FS_32           4'h3
`define B0_48              16'h3A1D
`define B1_48              16'h0E7E
`define A1_48              16'h5461
`define B0_441             16'h3BDE
`define B1_441             16'h0D33
`define A1_441             16'h5155
`define B0_32              16'h43F1
`define B1_32              16'h0876
`define A1_32              16'h4485
`define COEF_FRAC          6'h0F
`define ATTEN_STEPS        8'h0C
`define SAMPLE_MAX         24'h7FFFFF
`define SAMPLE_MIN         24'h800000
`define LFSR_SEED          32'hACE1ACE1
`define LFSR_TAPS          32'h80200003
`define FIFO_DEPTH         16
`define FIFO_AW            4
`endif

//--- src_ctrl_pkg.sv
// Types shared by the converter control logic
package src_ctrl_pkg;
    typedef logic signed [23:0] sample_type;
    typedef logic [7:0]         byte_type;
    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_DEEMPH = 3'h1,
        ST_ATTEN  = 3'h3,
        ST_DITHER = 3'h2,
        ST_OUT    = 3'h6
    } proc_state_type;
endpackage : src_ctrl_pkg

//--- sample_rate_converter_control.sv
// Sample FIFO and the control/post-processing stage of the two-channel converter
`include "src_ctrl_params.svh"

module src_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = `FIFO_DEPTH,
    parameter int AW    = `FIFO_AW
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_clk_en,
    input  wire logic             i_push_valid,
    output logic                  o_push_ready,
    input  wire logic [WIDTH-1:0] i_push_data,
    output logic                  o_pop_valid,
    input  wire logic             i_pop_ready,
    output logic [WIDTH-1:0]      o_pop_data,
    output logic                  o_full
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [AW:0]      count, next_count;
    logic             push, pop, next_ready;

    always_comb begin
        push        = i_push_valid && o_push_ready;
        pop         = i_pop_ready && o_pop_valid;
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count  = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        next_ready  = next_count != DEPTH[AW:0];
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr       <= '0;
            rd_ptr       <= '0;
            count        <= '0;
            o_push_ready <= 1'b0;
        end else if (i_clk_en) begin
            wr_ptr       <= next_wr_ptr;
            rd_ptr       <= next_rd_ptr;
            count        <= next_count;
            o_push_ready <= next_ready;
        end
    end

    // Storage has no reset: contents are never read before being written
    always_ff @(posedge i_clk) begin
        if (i_clk_en && push) begin
            mem[wr_ptr] <= i_push_data;
        end
    end

    assign o_pop_valid = count != '0;
    assign o_pop_data  = mem[rd_ptr];
    assign o_full      = !o_push_ready;
endmodule : src_fifo

module sample_rate_converter_control (
    input  wire logic                    i_core_clk,
    input  wire logic                    i_resetn,
    input  wire logic                    i_clk_en,
    input  wire logic [6:0]              i_reg_addr,
    input  wire src_ctrl_pkg::byte_type  i_reg_wdata,
    input  wire logic                    i_reg_write,
    input  wire logic                    i_reg_read,
    output src_ctrl_pkg::byte_type       o_reg_rdata,
    input  wire logic                    i_in_valid,
    output logic                         o_in_ready,
    input  wire src_ctrl_pkg::sample_type i_in_left,
    input  wire src_ctrl_pkg::sample_type i_in_right,
    output logic                         o_out_valid,
    input  wire logic                    i_out_ready,
    output src_ctrl_pkg::sample_type     o_out_left,
    output src_ctrl_pkg::sample_type     o_out_right,
    input  wire logic                    i_rx_cs_emphasis,
    input  wire logic [3:0]              i_rx_cs_fs_code,
    output logic [1:0]                   o_ref_clock_select,
    output logic                         o_direct_downsample,
    output logic [6:0]                   o_prebuffer_depth,
    output logic [1:0]                   o_output_word_length,
    output logic                         o_deemph_active
);
    import src_ctrl_pkg::*;

    function automatic logic [6:0] depth_of(input logic [1:0] sel);
        case (sel)
            2'h0:    depth_of = `DEPTH_64;
            2'h1:    depth_of = `DEPTH_32;
            2'h2:    depth_of = `DEPTH_16;
            default: depth_of = `DEPTH_8;
        endcase
    endfunction : depth_of

    function automatic sample_type sat24(input logic signed [41:0] v);
        if (v > $signed({18'h0, `SAMPLE_MAX}))      sat24 = `SAMPLE_MAX;
        else if (v < $signed({18'h3FFFF, `SAMPLE_MIN})) sat24 = `SAMPLE_MIN;
        else                                        sat24 = v[23:0];
    endfunction : sat24

    // First-order shelf: y = b0*x - b1*x1 + a1*y1, unity gain at DC
    function automatic sample_type deemph_step(input sample_type x, input sample_type x1,
                                               input sample_type y1, input logic [1:0] sel);
        logic [15:0]        b0, b1, a1;
        logic signed [41:0] acc;
        b0 = `B0_48;
        b1 = `B1_48;
        a1 = `A1_48;
        case (sel)
            `DEM_441: begin b0 = `B0_441; b1 = `B1_441; a1 = `A1_441; end
            `DEM_32:  begin b0 = `B0_32;  b1 = `B1_32;  a1 = `A1_32;  end
            default:  begin b0 = `B0_48;  b1 = `B1_48;  a1 = `A1_48;  end
        endcase
        acc = 42'(x) * 42'($signed({1'b0, b0})) - 42'(x1) * 42'($signed({1'b0, b1}))
            + 42'(y1) * 42'($signed({1'b0, a1}));
        deemph_step = sat24(acc >>> `COEF_FRAC);
    endfunction : deemph_step

    // Gain = 10^(-code/40): a 12-entry half-decibel mantissa plus a shift per 6 dB
    function automatic sample_type atten(input sample_type x, input byte_type code);
        logic [15:0]        mant;
        logic [4:0]         sh;
        logic signed [41:0] prod;
        sh = 5'(code / `ATTEN_STEPS);
        case (8'(code % `ATTEN_STEPS))
            8'h00: mant = 16'h8000;  8'h01: mant = 16'h78D7;  8'h02: mant = 16'h7215;
            8'h03: mant = 16'h6BB3;  8'h04: mant = 16'h65AD;  8'h05: mant = 16'h5FFD;
            8'h06: mant = 16'h5A9E;  8'h07: mant = 16'h558C;  8'h08: mant = 16'h50C3;
            8'h09: mant = 16'h4C3F;  8'h0A: mant = 16'h47FB;  default: mant = 16'h43F4;
        endcase
        prod  = 42'(x) * 42'($signed({1'b0, mant}));
        atten = prod[23 + 15:0] == '0 ? '0 : 24'(prod >>> (6'(sh) + `COEF_FRAC));
    endfunction : atten

    // Triangular dither: sum of two uniform values spanning one output LSB each
    function automatic sample_type dither(input sample_type x, input logic [1:0] output_word_length,
                                          input byte_type ra, input byte_type rb);
        logic [3:0]         k;
        byte_type           mask;
        logic signed [41:0] v;
        case (output_word_length)
            2'h1:    k = 4'h4;
            2'h2:    k = 4'h6;
            2'h3:    k = 4'h8;
            default: k = 4'h0;
        endcase
        mask = 8'((9'h001 << k) - 9'h001);
        v    = 42'(x) + 42'(ra & mask) + 42'(rb & mask) - 42'(mask) - 42'h1;
        if (k == 4'h0) dither = x;
        else           dither = sat24(v) & ~24'(mask);
    endfunction : dither

    logic rst_meta, rst_n;
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Control registers
    byte_type   ctrl1, filt, wlen, att_l, att_r;
    byte_type   next_ctrl1, next_filt, next_wlen, next_att_l, next_att_r, next_rdata;
    logic [1:0] cfg_dem, next_cfg_dem;
    logic       regs_wr, prime_restart;

    always_comb begin
        regs_wr    = i_reg_write;
        next_ctrl1 = ctrl1;
        next_filt  = filt;
        next_wlen  = wlen;
        next_att_l = att_l;
        next_att_r = att_r;
        next_rdata = o_reg_rdata;
        if (regs_wr && i_reg_addr == `REG_CTRL1) begin
            next_ctrl1[`CTRL1_TRACK] = i_reg_wdata[`CTRL1_TRACK];
            next_ctrl1[`CTRL1_MUTE]  = i_reg_wdata[`CTRL1_MUTE];
            next_ctrl1[`CTRL1_INSRC] = i_reg_wdata[`CTRL1_INSRC];
            if (i_reg_wdata[`CTRL1_REFCLK] != `REF_RESERVED) begin
                next_ctrl1[`CTRL1_REFCLK] = i_reg_wdata[`CTRL1_REFCLK];
            end
        end
        if (regs_wr && i_reg_addr == `REG_FILTER) begin
            next_filt = {2'h0, i_reg_wdata[5:0]};
        end
        if (regs_wr && i_reg_addr == `REG_WORDLEN) begin
            next_wlen = {i_reg_wdata[`WL_OWL], 6'h00};
        end
        if (regs_wr && i_reg_addr == `REG_ATTEN_L) next_att_l = i_reg_wdata;
        if (regs_wr && i_reg_addr == `REG_ATTEN_R) next_att_r = i_reg_wdata;
        if (i_reg_read) begin
            case (i_reg_addr)
                `REG_CTRL1:   next_rdata = ctrl1;
                `REG_FILTER:  next_rdata = filt;
                `REG_WORDLEN: next_rdata = wlen;
                `REG_ATTEN_L: next_rdata = att_l;
                `REG_ATTEN_R: next_rdata = att_r;
                default:      next_rdata = `RESET_BYTE;
            endcase
        end
        prime_restart = regs_wr && i_reg_addr == `REG_FILTER;
        // Channel status is a level from the receiver, so it is followed every cycle
        if (filt[`FILT_AUTO]) begin
            if (!i_rx_cs_emphasis)                   next_cfg_dem = `DEM_OFF;
            else if (i_rx_cs_fs_code == `CS_FS_48)   next_cfg_dem = `DEM_48;
            else if (i_rx_cs_fs_code == `CS_FS_441)  next_cfg_dem = `DEM_441;
            else if (i_rx_cs_fs_code == `CS_FS_32)   next_cfg_dem = `DEM_32;
            else                                     next_cfg_dem = `DEM_OFF;
        end else begin
            next_cfg_dem = filt[`FILT_DEM];
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl1                <= `RESET_BYTE;
            filt                 <= `RESET_BYTE;
            wlen                 <= `RESET_BYTE;
            att_l                <= `RESET_BYTE;
            att_r                <= `RESET_BYTE;
            o_reg_rdata          <= `RESET_BYTE;
            cfg_dem              <= `DEM_OFF;
            o_ref_clock_select   <= 2'h0;
            o_direct_downsample  <= 1'b0;
            o_prebuffer_depth    <= `DEPTH_64;
            o_output_word_length <= 2'h0;
            o_deemph_active      <= 1'b0;
        end else if (i_clk_en) begin
            ctrl1                <= next_ctrl1;
            filt                 <= next_filt;
            wlen                 <= next_wlen;
            att_l                <= next_att_l;
            att_r                <= next_att_r;
            o_reg_rdata          <= next_rdata;
            cfg_dem              <= next_cfg_dem;
            o_ref_clock_select   <= next_ctrl1[`CTRL1_REFCLK];
            o_direct_downsample  <= next_filt[`FILT_DDN];
            o_prebuffer_depth    <= depth_of(next_filt[`FILT_PREBUFFER_DEPTH_SELECT]);
            o_output_word_length <= next_wlen[`WL_OWL];
            o_deemph_active      <= next_cfg_dem != `DEM_OFF;
        end
    end

    // Sample path
    logic        fifo_valid, fifo_ready, fifo_full;
    logic [47:0] fifo_data;

    src_fifo #(.WIDTH(48), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) u_fifo (
        .i_clk        (i_core_clk),
        .i_rst_n      (rst_n),
        .i_clk_en     (i_clk_en),
        .i_push_valid (i_in_valid),
        .o_push_ready (o_in_ready),
        .i_push_data  ({i_in_left, i_in_right}),
        .o_pop_valid  (fifo_valid),
        .i_pop_ready  (fifo_ready),
        .o_pop_data   (fifo_data),
        .o_full       (fifo_full)
    );

    proc_state_type state, next_state;
    sample_type     sl, sr, xl1, xr1, yl1, yr1;
    sample_type     next_sl, next_sr, next_xl1, next_xr1, next_yl1, next_yr1;
    sample_type     next_out_l, next_out_r;
    logic [6:0]     primed_cnt, next_primed_cnt;
    logic [31:0]    lfsr, next_lfsr;
    logic           primed, next_out_valid;

    always_comb begin
        next_state      = state;
        next_sl         = sl;
        next_sr         = sr;
        next_xl1        = xl1;
        next_xr1        = xr1;
        next_yl1        = yl1;
        next_yr1        = yr1;
        next_lfsr       = lfsr;
        next_out_l      = o_out_left;
        next_out_r      = o_out_right;
        next_out_valid  = o_out_valid;
        // Full FIFO also releases draining: the deepest settings exceed its storage
        primed          = primed_cnt >= o_prebuffer_depth || fifo_full;
        fifo_ready      = state == ST_IDLE && primed;
        next_primed_cnt = primed_cnt;
        if (i_in_valid && o_in_ready && primed_cnt != `DEPTH_64) begin
            next_primed_cnt = primed_cnt + 7'h01;
        end
        if (prime_restart) next_primed_cnt = 7'h00;
        case (state)
            ST_IDLE: begin
                if (fifo_ready && fifo_valid) begin
                    next_sl    = fifo_data[47:24];
                    next_sr    = fifo_data[23:0];
                    next_state = ST_DEEMPH;
                end
            end
            ST_DEEMPH: begin
                next_xl1 = sl;
                next_xr1 = sr;
                if (cfg_dem != `DEM_OFF) begin
                    next_sl = deemph_step(sl, xl1, yl1, cfg_dem);
                    next_sr = deemph_step(sr, xr1, yr1, cfg_dem);
                end
                next_yl1   = next_sl;
                next_yr1   = next_sr;
                next_state = ST_ATTEN;
            end
            ST_ATTEN: begin
                next_sl    = atten(sl, att_l);
                next_sr    = atten(sr, ctrl1[`CTRL1_TRACK] ? att_l : att_r);
                next_state = ST_DITHER;
            end
            ST_DITHER: begin
                next_lfsr = {lfsr[30:0], ^(lfsr & `LFSR_TAPS)};
                if (ctrl1[`CTRL1_MUTE]) begin
                    next_out_l = '0;
                    next_out_r = '0;
                end else begin
                    next_out_l = dither(sl, wlen[`WL_OWL], lfsr[7:0], lfsr[15:8]);
                    next_out_r = dither(sr, wlen[`WL_OWL], lfsr[23:16], lfsr[31:24]);
                end
                next_out_valid = 1'b1;
                next_state     = ST_OUT;
            end
            ST_OUT: begin
                if (i_out_ready) begin
                    next_out_valid = 1'b0;
                    next_state     = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state       <= ST_IDLE;
            sl          <= '0;
            sr          <= '0;
            xl1         <= '0;
            xr1         <= '0;
            yl1         <= '0;
            yr1         <= '0;
            lfsr        <= `LFSR_SEED;
            primed_cnt  <= 7'h00;
            o_out_left  <= '0;
            o_out_right <= '0;
            o_out_valid <= 1'b0;
        end else if (i_clk_en) begin
            state       <= next_state;
            sl          <= next_sl;
            sr          <= next_sr;
            xl1         <= next_xl1;
            xr1         <= next_xr1;
            yl1         <= next_yl1;
            yr1         <= next_yr1;
            lfsr        <= next_lfsr;
            primed_cnt  <= next_primed_cnt;
            o_out_left  <= next_out_l;
            o_out_right <= next_out_r;
            o_out_valid <= next_out_valid;
        end
    end

    a_ref_reserved: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        o_ref_clock_select != `REF_RESERVED) else $error("reserved reference select");
    a_ref_write: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        i_clk_en && i_reg_write && i_reg_addr == `REG_CTRL1 && i_reg_wdata[`CTRL1_REFCLK] == 2'h1
        |=> o_ref_clock_select == 2'h1) else $error("reference select not taken");
    a_mute_zero: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        $rose(o_out_valid) && $past(ctrl1[`CTRL1_MUTE])
        |-> o_out_left == '0 && o_out_right == '0) else $error("muted sample not zero");
    a_prebuf_gate: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        i_clk_en && state == ST_IDLE && fifo_valid && !fifo_full
        && primed_cnt < depth_of(filt[`FILT_PREBUFFER_DEPTH_SELECT]) |=> state == ST_IDLE)
        else $error("drained before pre-buffer filled");
    a_mode_bit: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        i_clk_en && i_reg_write && i_reg_addr == `REG_FILTER
        |=> o_direct_downsample == $past(i_reg_wdata[`FILT_DDN])) else $error("mode bit lost");
    a_auto_ignore: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        i_clk_en && filt[`FILT_AUTO] && !i_rx_cs_emphasis && $stable(filt)
        |=> !o_deemph_active) else $error("manual de-emphasis used in auto mode");
    a_filt_layout: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        i_clk_en && i_reg_read && i_reg_addr == `REG_FILTER
        |=> o_reg_rdata[7:6] == 2'h0) else $error("filter register high bits set");
    a_wlen_layout: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        i_clk_en && i_reg_read && i_reg_addr == `REG_WORDLEN
        |=> o_reg_rdata[5:0] == 6'h00) else $error("word-length low bits set");
    a_word_16: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        $rose(o_out_valid) && $past(wlen[`WL_OWL]) == 2'h3
        |-> o_out_left[7:0] == 8'h00 && o_out_right[7:0] == 8'h00)
        else $error("16-bit output has low bits");
endmodule : sample_rate_converter_control

//--- tb_top.sv
// Self-checking bench of the converter control block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import src_ctrl_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_resetn, i_clk_en, i_reg_write, i_reg_read, i_in_valid, o_in_ready;
    logic o_out_valid, i_out_ready, i_rx_cs_emphasis, o_direct_downsample, o_deemph_active;
    logic [6:0] i_reg_addr, o_prebuffer_depth;
    logic [3:0] i_rx_cs_fs_code;
    logic [1:0] o_ref_clock_select, o_output_word_length;
    byte_type i_reg_wdata, o_reg_rdata, rd;
    sample_type i_in_left, i_in_right, o_out_left, o_out_right, ol, orr;
    int errors, checked, n;
    // Row: addr, write, readback, channel status, expected config outputs
    logic [55:0] rows [19] = '{56'h2D040400104000, 56'h2D0B0B00204000, 56'h2D0C0800204000,
        56'h2D000000004000, 56'h2EFF3F00010800, 56'h2E010100002000, 56'h2E020200001000,
        56'h2E242410014001, 56'h2E202015004000, 56'h2E383813004001, 56'h2E080800004001,
        56'h2E101000004001, 56'h2E181800004001, 56'h2E000000004000, 56'h2FFFC000004030,
        56'h2F404000004010, 56'h2F808000004020, 56'h40FF0000004020, 56'h2F000000004000};
    wire [23:0] cfg = {2'b0, o_ref_clock_select, 3'b0, o_direct_downsample, 1'b0,
        o_prebuffer_depth, 2'b0, o_output_word_length, 3'b0, o_deemph_active};
    always #5 i_core_clk = ~i_core_clk;
    sample_rate_converter_control i_dut (.i_core_clk, .i_resetn, .i_clk_en, .i_reg_addr,
        .i_reg_wdata, .i_reg_write, .i_reg_read, .o_reg_rdata, .i_in_valid, .o_in_ready,
        .i_in_left, .i_in_right, .o_out_valid, .i_out_ready, .o_out_left, .o_out_right,
        .i_rx_cs_emphasis, .i_rx_cs_fs_code, .o_ref_clock_select, .o_direct_downsample,
        .o_prebuffer_depth, .o_output_word_length, .o_deemph_active);
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic reg_wr(input logic [6:0] a, input byte_type d);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_write <= 1'b1;
        @(posedge i_core_clk);
        i_reg_write <= 1'b0;
        @(posedge i_core_clk);
    endtask : reg_wr
    task automatic reg_rd(input logic [6:0] a);
        i_reg_addr <= a;
        i_reg_read <= 1'b1;
        @(posedge i_core_clk);
        i_reg_read <= 1'b0;
        @(negedge i_core_clk);
        rd = o_reg_rdata;
        @(posedge i_core_clk);
    endtask : reg_rd
    // Leaves valid up so back-to-back pushes never assign it twice in one step
    task automatic push();
        i_in_valid <= 1'b1;
        i_in_left <= 24'sh400000;
        i_in_right <= 24'sh400000;
        for (int k = 0; k < 200; k++) begin
            @(negedge i_core_clk);
            if (o_in_ready === 1'b1) break;
        end
        @(posedge i_core_clk);
    endtask : push
    task automatic pull();
        for (int k = 0; k < 200; k++) begin
            @(negedge i_core_clk);
            if (o_out_valid === 1'b1) break;
        end
        ol = o_out_left;
        orr = o_out_right;
        @(posedge i_core_clk);
        i_out_ready <= 1'b1;
        @(posedge i_core_clk);
        i_out_ready <= 1'b0;
    endtask : pull
    task automatic batch(input sample_type el, input sample_type er, input int tol);
        logic signed [24:0] dl, dr;
        for (int k = 0; k < 8; k++) push();
        i_in_valid <= 1'b0;
        for (int k = 0; k < 8; k++) begin
            pull();
            dl = {ol[23], ol} - {el[23], el};
            dr = {orr[23], orr} - {er[23], er};
            chk({ol[7:0], orr[7:0]}, 16'h0);
            chk(dl <= tol && dl >= -tol && dr <= tol && dr >= -tol, 1'b1);
        end
        $display("Sample batch done");
    endtask : batch
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude
    initial begin
        repeat (20000) @(posedge i_core_clk);
        errors++;
        conclude();
    end
    initial begin
        {i_resetn, i_reg_write, i_reg_read, i_in_valid, i_out_ready} <= '0;
        {i_rx_cs_emphasis, i_rx_cs_fs_code, i_reg_addr, i_reg_wdata} <= '0;
        {i_in_left, i_in_right} <= '0;
        i_clk_en <= 1'b1;
        errors = 0;
        checked = 0;
        repeat (8) @(posedge i_core_clk);
        chk({o_in_ready, cfg}, 25'h0004000);
        i_resetn <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        $display("Reset defaults done");
        foreach (rows[i]) begin
            i_rx_cs_emphasis <= rows[i][28];
            i_rx_cs_fs_code <= rows[i][27:24];
            reg_wr(rows[i][54:48], rows[i][47:40]);
            reg_rd(rows[i][54:48]);
            chk(rd, rows[i][39:32]);
            chk(cfg, rows[i][23:0]);
        end
        $display("Register table done");
        reg_wr(7'h2F, 8'hC0);
        reg_wr(7'h31, 8'hFF);
        reg_wr(7'h2E, 8'h03);
        batch(24'sh400000, 24'sh0, 'h1000);
        reg_wr(7'h2D, 8'h40);
        reg_wr(7'h30, 8'h0C);
        batch(24'sh200000, 24'sh200000, 'h4000);
        reg_wr(7'h2D, 8'h50);
        batch(24'sh0, 24'sh0, 0);
        reg_wr(7'h2D, 8'h00);
        // Far side stalls while the buffer fills until it refuses
        i_in_valid <= 1'b1;
        n = 0;
        for (int k = 0; k < 40; k++) begin
            @(negedge i_core_clk);
            if (o_in_ready !== 1'b1) break;
            @(posedge i_core_clk);
            n++;
        end
        @(posedge i_core_clk);
        i_in_valid <= 1'b0;
        chk(n > 15, 1'b1);
        repeat (n) pull();
        repeat (8) @(posedge i_core_clk);
        chk({o_out_valid, o_in_ready}, 2'b01);
        $display("Buffer fill and drain done");
        // Steady input: the shelf has unity gain at DC, so only attenuation shows
        reg_wr(7'h2E, 8'h0B);
        batch(24'sh200000, 24'sh0, 'h100);
        i_resetn <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        chk(cfg, 24'h004000);
        i_resetn <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        // A write while the clock enable is low must leave the register untouched
        i_clk_en <= 1'b0;
        reg_wr(7'h2E, 8'h04);
        i_clk_en <= 1'b1;
        reg_rd(7'h2E);
        chk(rd, 8'h00);
        $display("Second reset done");
        conclude();
    end
endmodule : tb_top
